// >>> hw/scs_cfg_space.sv
// What this block does
// [R1] each port has its own register space, all with the same offset layout
// [R2] every register is reachable by configuration requests and by memory requests not from downstream
// [R3] offset 40h returns power management ID 01h, next pointer 48h
// [R4] offset 48h returns MSI ID 05h, next pointer 68h
// [R5] offset 68h returns PCI Express ID 10h, next pointer A4h
// [R6] offset A4h returns subsystem ID 0Dh, next 00h ending the list
// [R7] offset 100h returns serial number ID 0003h, version 1h, next FB4h
// [R8] offset FB4h returns error reporting ID 0001h, next 138h or 148h
// [R9] power budget 138h-144h exists upstream only, ID 0004h, next 148h
// [R10] offset 148h returns virtual channel ID 0002h, next 950h or 520h
// [R11] access control at 520h-52Ch exists downstream only, ID 000Dh, next 950h
// [R12] offset 950h returns vendor ID 000Bh, next 000h ending the list
// [R13] chip setup regions exist on the upstream port only
// [R14] a shared register write is seen through every port
// [R15] the eight listed offsets are single copies shared by all ports
// [R16] capability pointer at 34h points at 40h
// [R17] each port spans a 4-KB space, PCI region plus extended region
// [R18] memory window maps port N at N times 1000h
// [R19] memory requests not from downstream and longer than one DWord end in completer abort
// [R20] sideband writes may change registers read-only to software
// [R21] unimplemented or absent offsets read zero and ignore writes
`timescale 1ns/10ps
`include "scs_params.svh"
module scs_cfg_space (
  // clock and reset
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_NRST,
  // host request
  input  wire logic              I_REQ_VALID,
  input  wire logic              I_REQ_IS_MEM,
  input  wire logic              I_REQ_WRITE,
  input  wire logic              I_REQ_FROM_DS,
  input  wire logic [1:0]        I_REQ_PORT,
  input  wire logic [13:0]       I_REQ_ADDR,
  input  wire logic [9:0]        I_REQ_LEN,
  input  wire logic [3:0]        I_REQ_BE,
  input  wire logic [31:0]       I_REQ_WDATA,
  // sideband initialisation write
  input  wire logic              I_SB_VALID,
  input  wire logic [1:0]        I_SB_PORT,
  input  wire logic [11:0]       I_SB_OFF,
  input  wire logic [3:0]        I_SB_BE,
  input  wire logic [31:0]       I_SB_WDATA,
  // completion
  output logic                   O_CPL_VALID,
  output scs_pkg::scs_cpl_t      O_CPL_STATUS,
  output logic [31:0]            O_CPL_DATA
);
  import scs_pkg::*;

  // ****************************************************************
  // request decode
  // ****************************************************************
  scs_dec_if req_dec ();
  scs_dec_if sb_dec ();

  logic        is_ds_mem;
  logic        long_mem;
  logic        req_ok;
  logic        cfg_wr;
  logic        rd_now;
  logic [1:0]  req_port;
  logic [11:0] req_off;
  scs_cpl_t    err_st;

  // memory window selects the port by the 4-KB slice
  always_comb begin
    if (I_REQ_IS_MEM) begin
      req_port = I_REQ_ADDR[`SCS_MEM_PORT_MSB:`SCS_MEM_PORT_LSB];  // R18
    end else begin
      req_port = I_REQ_PORT;
    end
    req_off = I_REQ_ADDR[11:0];  // R17
  end

  assign req_dec.port = req_port;  // R1
  assign req_dec.off  = req_off;
  assign sb_dec.port  = I_SB_PORT;
  assign sb_dec.off   = I_SB_OFF;

  scs_map_decode u_req_map (
    .dec (req_dec)
  );

  scs_map_decode u_sb_map (
    .dec (sb_dec)
  );

  assign is_ds_mem = I_REQ_IS_MEM && I_REQ_FROM_DS;
  assign long_mem  = I_REQ_IS_MEM && (I_REQ_LEN != `SCS_ONE_DWORD);  // R19
  assign req_ok    = !is_ds_mem && !long_mem;  // R2
  assign cfg_wr    = I_REQ_VALID && I_REQ_WRITE && req_ok;
  assign rd_now    = I_REQ_VALID && !I_REQ_WRITE && req_ok;

  always_comb begin
    if (is_ds_mem) begin
      err_st = SCS_CPL_UR;
    end else if (long_mem) begin
      err_st = SCS_CPL_CA;  // R19
    end else begin
      err_st = SCS_CPL_SC;
    end
  end

  // ****************************************************************
  // shared single copies
  // ****************************************************************
  localparam logic [31:0] SH_RST [8] = '{`SCS_RST_ID, `SCS_RST_CLASS, `SCS_RST_SSID,
                                         `SCS_RST_SN_LOW, `SCS_RST_SN_HIGH, `SCS_RST_VS_HDR,
                                         `SCS_RST_FIX_ID, `SCS_RST_FIX_REV};
  localparam logic [31:0] UP_MASK [8] = '{`SCS_MASK_PB_SEL, `SCS_MASK_ALL, `SCS_MASK_ALL,
                                          `SCS_MASK_ALL, `SCS_MASK_ALL, `SCS_MASK_ALL,
                                          `SCS_MASK_ALL, `SCS_MASK_ALL};

  logic [31:0] shared_q [8];
  logic [31:0] up_q     [8];
  logic [31:0] local_q  [4];

  // shared words ignore the port: one copy answers every port
  for (genvar i = 0; i < 8; i++) begin : g_shared
    scs_word_reg #(
      .RST     (SH_RST[i]),
      .RW_MASK (`SCS_MASK_RO)
    ) u_reg (
      .i_clk       (I_CLK_SYS),
      .i_nrst      (I_NRST),
      .i_cfg_we    (cfg_wr && req_dec.kind == SCS_KIND_SHARED && req_dec.idx == 3'(i)),
      .i_cfg_be    (I_REQ_BE),
      .i_cfg_wdata (I_REQ_WDATA),
      .i_sb_we     (I_SB_VALID && sb_dec.kind == SCS_KIND_SHARED && sb_dec.idx == 3'(i)),
      .i_sb_be     (I_SB_BE),
      .i_sb_wdata  (I_SB_WDATA),
      .o_q         (shared_q[i])
    );  // R14 R15 R20
  end

  // ****************************************************************
  // upstream-only setup words
  // ****************************************************************
  for (genvar i = 0; i < 8; i++) begin : g_up
    scs_word_reg #(
      .RST     (`SCS_RST_ZERO),
      .RW_MASK (UP_MASK[i])
    ) u_reg (
      .i_clk       (I_CLK_SYS),
      .i_nrst      (I_NRST),
      .i_cfg_we    (cfg_wr && req_dec.kind == SCS_KIND_UPREG && req_dec.idx == 3'(i)),
      .i_cfg_be    (I_REQ_BE),
      .i_cfg_wdata (I_REQ_WDATA),
      .i_sb_we     (I_SB_VALID && sb_dec.kind == SCS_KIND_UPREG && sb_dec.idx == 3'(i)),
      .i_sb_be     (I_SB_BE),
      .i_sb_wdata  (I_SB_WDATA),
      .o_q         (up_q[i])
    );  // R13
  end

  // ****************************************************************
  // per-port power management control
  // ****************************************************************
  for (genvar p = 0; p < 4; p++) begin : g_local
    scs_word_reg #(
      .RST     (`SCS_RST_ZERO),
      .RW_MASK (`SCS_MASK_PM_CSR)
    ) u_reg (
      .i_clk       (I_CLK_SYS),
      .i_nrst      (I_NRST),
      .i_cfg_we    (cfg_wr && req_dec.kind == SCS_KIND_LOCAL && req_port == 2'(p)),
      .i_cfg_be    (I_REQ_BE),
      .i_cfg_wdata (I_REQ_WDATA),
      .i_sb_we     (I_SB_VALID && sb_dec.kind == SCS_KIND_LOCAL && I_SB_PORT == 2'(p)),
      .i_sb_be     (I_SB_BE),
      .i_sb_wdata  (I_SB_WDATA),
      .o_q         (local_q[p])
    );  // R1
  end

  // ****************************************************************
  // read data and completion
  // ****************************************************************
  logic [31:0] rd_d;

  always_comb begin
    case (req_dec.kind)
      SCS_KIND_CONST:  rd_d = req_dec.cval;  // R3 R4 R5 R6 R7 R8 R9 R10 R11 R12 R16
      SCS_KIND_SHARED: rd_d = shared_q[req_dec.idx];  // R14
      SCS_KIND_UPREG:  rd_d = up_q[req_dec.idx];  // R13
      SCS_KIND_LOCAL:  rd_d = local_q[req_port];  // R1
      default:         rd_d = 32'h0000_0000;  // R21
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      O_CPL_VALID <= 1'b0;
    end else begin
      O_CPL_VALID <= I_REQ_VALID;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      O_CPL_STATUS <= SCS_CPL_SC;
      O_CPL_DATA   <= 32'h0000_0000;
    end else if (I_REQ_VALID) begin
      O_CPL_STATUS <= err_st;
      O_CPL_DATA   <= rd_now ? rd_d : 32'h0000_0000;  // R2
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_pm_header: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)  // R3
    rd_now && req_off == `SCS_OFF_PM_CAP |=>
      O_CPL_VALID && O_CPL_DATA[15:0] == {`SCS_PM_NEXT, `SCS_PM_ID})
    else $error("power management header wrong");

  a_msi_header: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)  // R4
    rd_now && req_off == `SCS_OFF_MSI_CAP |=>
      O_CPL_DATA[15:0] == {`SCS_MSI_NEXT, `SCS_MSI_ID})
    else $error("msi header wrong");

  a_pcie_header: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)  // R5
    rd_now && req_off == `SCS_OFF_PCIE_CAP |=>
      O_CPL_DATA[15:0] == {`SCS_PCIE_NEXT, `SCS_PCIE_ID})
    else $error("pci express header wrong");

  a_ssid_header: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)  // R6
    rd_now && req_off == `SCS_OFF_SSID_CAP |=>
      O_CPL_DATA[15:0] == {`SCS_SSID_NEXT, `SCS_SSID_ID})
    else $error("subsystem header wrong");

  a_dsn_header: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)  // R7
    rd_now && req_off == `SCS_OFF_DSN_CAP |=>
      O_CPL_DATA == {`SCS_DSN_NEXT, `SCS_EXT_VER, `SCS_DSN_ID})
    else $error("serial number header wrong");

  a_aer_next: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)  // R8
    rd_now && req_off == `SCS_OFF_AER_CAP |=>
      O_CPL_DATA[31:20] == ($past(req_port) == `SCS_UP_PORT ? `SCS_AER_NEXT_UP
                                                             : `SCS_AER_NEXT_DN)
      && O_CPL_DATA[15:0] == `SCS_AER_ID)
    else $error("error reporting link wrong");

  a_pb_presence: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)  // R9
    rd_now && req_off == `SCS_OFF_PB_CAP |=>
      O_CPL_DATA == ($past(req_port) == `SCS_UP_PORT ?
                     {`SCS_PB_NEXT, `SCS_EXT_VER, `SCS_PB_ID} : 32'h0000_0000))
    else $error("power budget presence wrong");

  a_vc_next: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)  // R10
    rd_now && req_off == `SCS_OFF_VC_CAP |=>
      O_CPL_DATA[31:20] == ($past(req_port) == `SCS_UP_PORT ? `SCS_VC_NEXT_UP
                                                             : `SCS_VC_NEXT_DN))
    else $error("virtual channel link wrong");

  a_acs_presence: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)  // R11
    rd_now && req_off == `SCS_OFF_ACS_CAP && req_port != `SCS_UP_PORT |=>
      O_CPL_DATA == {`SCS_ACS_NEXT, `SCS_EXT_VER, `SCS_ACS_ID})
    else $error("access control header wrong");

  a_vs_end: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)  // R12
    rd_now && req_off == `SCS_OFF_VS_CAP |=>
      O_CPL_DATA == {`SCS_VS_NEXT, `SCS_EXT_VER, `SCS_VS_ID})
    else $error("vendor header wrong");

  a_up_regions: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)  // R13
    rd_now && req_off == `SCS_OFF_PHY && req_port != `SCS_UP_PORT |=>
      O_CPL_DATA == 32'h0000_0000)
    else $error("setup region seen on downstream port");

  a_shared_copy: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)  // R14
    I_SB_VALID && I_SB_OFF == `SCS_OFF_SN_LOW && I_SB_BE == 4'hF && !I_REQ_VALID ##1
      rd_now && req_off == `SCS_OFF_SN_LOW && !I_SB_VALID |=>
      O_CPL_DATA == $past(I_SB_WDATA, 2))
    else $error("shared copy not seen through other port");

  a_cap_ptr: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)  // R16
    rd_now && req_off == `SCS_OFF_CAP_PTR |=>
      O_CPL_DATA == {24'h00_0000, `SCS_FIRST_CAP})
    else $error("capability pointer wrong");

  a_len_abort: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)  // R19
    I_REQ_VALID && I_REQ_IS_MEM && !I_REQ_FROM_DS && I_REQ_LEN != `SCS_ONE_DWORD |=>
      O_CPL_VALID && O_CPL_STATUS == SCS_CPL_CA && O_CPL_DATA == 32'h0000_0000)
    else $error("long memory request not aborted");

  a_ro_kept: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)  // R20
    cfg_wr && req_dec.kind == SCS_KIND_SHARED && !I_SB_VALID |=>
      shared_q[$past(req_dec.idx)] == $past(shared_q[req_dec.idx]))
    else $error("software changed a read-only shared word");

  a_cpl_pulse: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)  // R2
    O_CPL_VALID == $past(I_REQ_VALID))
    else $error("completion pulse wrong");

  a_ds_refused: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)  // R2
    I_REQ_VALID && I_REQ_IS_MEM && I_REQ_FROM_DS |=>
      O_CPL_STATUS == SCS_CPL_UR && O_CPL_DATA == 32'h0000_0000)
    else $error("downstream memory request not refused");

  a_cfg_success: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)  // R2
    I_REQ_VALID && !I_REQ_IS_MEM |=>
      O_CPL_VALID && O_CPL_STATUS == SCS_CPL_SC)
    else $error("configuration request not completed");

  a_absent_zero: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)  // R21
    rd_now && req_dec.kind == SCS_KIND_NONE |=>
      O_CPL_DATA == 32'h0000_0000)
    else $error("absent offset read nonzero");
endmodule : scs_cfg_space

// >>> hw/scs_dec_if.sv
`timescale 1ns/10ps
interface scs_dec_if;
  import scs_pkg::*;
  logic      [1:0]  port;
  logic      [11:0] off;
  scs_kind_t        kind;
  logic      [2:0]  idx;
  logic      [31:0] cval;

  modport req (output port, output off, input kind, input idx, input cval);
  modport map (input port, input off, output kind, output idx, output cval);
endinterface : scs_dec_if

// >>> hw/scs_map_decode.sv
`timescale 1ns/10ps
`include "scs_params.svh"
module scs_map_decode (
  scs_dec_if.map dec
);
  import scs_pkg::*;

  function automatic logic [31:0] ext_hdr(input logic [15:0] id, input logic [11:0] nxt);
    ext_hdr = {nxt, `SCS_EXT_VER, id};
  endfunction : ext_hdr

  function automatic logic [31:0] std_hdr(input logic [7:0] id, input logic [7:0] nxt);
    std_hdr = {16'h0000, nxt, id};
  endfunction : std_hdr

  logic [11:0] dw;
  logic        up;

  always_comb begin
    dw       = {dec.off[11:2], 2'h0};
    up       = (dec.port == `SCS_UP_PORT);
    dec.kind = SCS_KIND_NONE;
    dec.idx  = 3'h0;
    dec.cval = 32'h0000_0000;
    case (dw)
      `SCS_OFF_ID:        begin dec.kind = SCS_KIND_SHARED; dec.idx = 3'h0; end
      `SCS_OFF_CLASS:     begin dec.kind = SCS_KIND_SHARED; dec.idx = 3'h1; end
      `SCS_OFF_SSID:      begin dec.kind = SCS_KIND_SHARED; dec.idx = 3'h2; end
      `SCS_OFF_SN_LOW:    begin dec.kind = SCS_KIND_SHARED; dec.idx = 3'h3; end
      `SCS_OFF_SN_HIGH:   begin dec.kind = SCS_KIND_SHARED; dec.idx = 3'h4; end
      `SCS_OFF_VS_HDR:    begin dec.kind = SCS_KIND_SHARED; dec.idx = 3'h5; end
      `SCS_OFF_FIX_ID:    begin dec.kind = SCS_KIND_SHARED; dec.idx = 3'h6; end
      `SCS_OFF_FIX_REV:   begin dec.kind = SCS_KIND_SHARED; dec.idx = 3'h7; end
      `SCS_OFF_PM_CSR:    begin dec.kind = SCS_KIND_LOCAL;  dec.idx = 3'h0; end
      `SCS_OFF_CAP_PTR:   begin
        dec.kind = SCS_KIND_CONST;
        dec.cval = {24'h00_0000, `SCS_FIRST_CAP};
      end
      `SCS_OFF_PM_CAP:    begin
        dec.kind = SCS_KIND_CONST;
        dec.cval = std_hdr(`SCS_PM_ID, `SCS_PM_NEXT);
      end
      `SCS_OFF_MSI_CAP:   begin
        dec.kind = SCS_KIND_CONST;
        dec.cval = std_hdr(`SCS_MSI_ID, `SCS_MSI_NEXT);
      end
      `SCS_OFF_PCIE_CAP:  begin
        dec.kind = SCS_KIND_CONST;
        dec.cval = std_hdr(`SCS_PCIE_ID, `SCS_PCIE_NEXT);
      end
      `SCS_OFF_SSID_CAP:  begin
        dec.kind = SCS_KIND_CONST;
        dec.cval = std_hdr(`SCS_SSID_ID, `SCS_SSID_NEXT);
      end
      `SCS_OFF_DSN_CAP:   begin
        dec.kind = SCS_KIND_CONST;
        dec.cval = ext_hdr(`SCS_DSN_ID, `SCS_DSN_NEXT);
      end
      `SCS_OFF_AER_CAP:   begin
        dec.kind = SCS_KIND_CONST;
        dec.cval = ext_hdr(`SCS_AER_ID, up ? `SCS_AER_NEXT_UP : `SCS_AER_NEXT_DN);
      end
      `SCS_OFF_VC_CAP:    begin
        dec.kind = SCS_KIND_CONST;
        dec.cval = ext_hdr(`SCS_VC_ID, up ? `SCS_VC_NEXT_UP : `SCS_VC_NEXT_DN);
      end
      `SCS_OFF_VS_CAP:    begin
        dec.kind = SCS_KIND_CONST;
        dec.cval = ext_hdr(`SCS_VS_ID, `SCS_VS_NEXT);
      end
      `SCS_OFF_PB_CAP:    begin
        if (up) begin
          dec.kind = SCS_KIND_CONST;
          dec.cval = ext_hdr(`SCS_PB_ID, `SCS_PB_NEXT);
        end
      end
      `SCS_OFF_ACS_CAP:   begin
        if (!up) begin
          dec.kind = SCS_KIND_CONST;
          dec.cval = ext_hdr(`SCS_ACS_ID, `SCS_ACS_NEXT);
        end
      end
      `SCS_OFF_PB_SEL:    begin if (up) begin dec.kind = SCS_KIND_UPREG; dec.idx = 3'h0; end end
      `SCS_OFF_PHY:       begin if (up) begin dec.kind = SCS_KIND_UPREG; dec.idx = 3'h1; end end
      `SCS_OFF_EEPROM:    begin if (up) begin dec.kind = SCS_KIND_UPREG; dec.idx = 3'h2; end end
      `SCS_OFF_I2C:       begin if (up) begin dec.kind = SCS_KIND_UPREG; dec.idx = 3'h3; end end
      `SCS_OFF_PORT_CFG:  begin if (up) begin dec.kind = SCS_KIND_UPREG; dec.idx = 3'h4; end end
      `SCS_OFF_GPIO:      begin if (up) begin dec.kind = SCS_KIND_UPREG; dec.idx = 3'h5; end end
      `SCS_OFF_LINK_WIDTH: begin if (up) begin dec.kind = SCS_KIND_UPREG; dec.idx = 3'h6; end end
      `SCS_OFF_CREDIT:    begin if (up) begin dec.kind = SCS_KIND_UPREG; dec.idx = 3'h7; end end
      default:            begin dec.kind = SCS_KIND_NONE; end
    endcase
  end
endmodule : scs_map_decode

// >>> hw/scs_params.svh
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH

// ****************************************************************
// port layout
// ****************************************************************
`define SCS_UP_PORT        2'h0
`define SCS_MEM_PORT_MSB   13
`define SCS_MEM_PORT_LSB   12
`define SCS_ONE_DWORD      10'h001

// ****************************************************************
// register offsets (byte offsets inside one port's 4-KB space)
// ****************************************************************
`define SCS_OFF_ID         12'h000
`define SCS_OFF_CLASS      12'h008
`define SCS_OFF_CAP_PTR    12'h034
`define SCS_OFF_PM_CAP     12'h040
`define SCS_OFF_PM_CSR     12'h044
`define SCS_OFF_MSI_CAP    12'h048
`define SCS_OFF_PCIE_CAP   12'h068
`define SCS_OFF_SSID_CAP   12'h0A4
`define SCS_OFF_SSID       12'h0A8
`define SCS_OFF_DSN_CAP    12'h100
`define SCS_OFF_SN_LOW     12'h104
`define SCS_OFF_SN_HIGH    12'h108
`define SCS_OFF_PB_CAP     12'h138
`define SCS_OFF_PB_SEL     12'h13C
`define SCS_OFF_VC_CAP     12'h148
`define SCS_OFF_PHY        12'h200
`define SCS_OFF_EEPROM     12'h260
`define SCS_OFF_I2C        12'h290
`define SCS_OFF_ACS_CAP    12'h520
`define SCS_OFF_PORT_CFG   12'h574
`define SCS_OFF_GPIO       12'h62C
`define SCS_OFF_LINK_WIDTH 12'h660
`define SCS_OFF_VS_CAP     12'h950
`define SCS_OFF_VS_HDR     12'h954
`define SCS_OFF_FIX_ID     12'h958
`define SCS_OFF_FIX_REV    12'h95C
`define SCS_OFF_CREDIT     12'h9F0
`define SCS_OFF_AER_CAP    12'hFB4

// ****************************************************************
// capability list links
// ****************************************************************
`define SCS_FIRST_CAP      8'h40
`define SCS_PM_ID          8'h01
`define SCS_PM_NEXT        8'h48
`define SCS_MSI_ID         8'h05
`define SCS_MSI_NEXT       8'h68
`define SCS_PCIE_ID        8'h10
`define SCS_PCIE_NEXT      8'hA4
`define SCS_SSID_ID        8'h0D
`define SCS_SSID_NEXT      8'h00
`define SCS_EXT_VER        4'h1
`define SCS_DSN_ID         16'h0003
`define SCS_DSN_NEXT       12'hFB4
`define SCS_AER_ID         16'h0001
`define SCS_AER_NEXT_UP    12'h138
`define SCS_AER_NEXT_DN    12'h148
`define SCS_PB_ID          16'h0004
`define SCS_PB_NEXT        12'h148
`define SCS_VC_ID          16'h0002
`define SCS_VC_NEXT_UP     12'h950
`define SCS_VC_NEXT_DN     12'h520
`define SCS_ACS_ID         16'h000D
`define SCS_ACS_NEXT       12'h950
`define SCS_VS_ID          16'h000B
`define SCS_VS_NEXT        12'h000

// ****************************************************************
// reset values and writable masks (identity values are arbitrary)
// ****************************************************************
`define SCS_RST_ID         32'h0001_0001
`define SCS_RST_CLASS      32'h0604_0000
`define SCS_RST_SSID       32'h0001_0001
`define SCS_RST_SN_LOW     32'h0000_0001
`define SCS_RST_SN_HIGH    32'h0000_0000
`define SCS_RST_VS_HDR     32'h0000_0000
`define SCS_RST_FIX_ID     32'h0001_0001
`define SCS_RST_FIX_REV    32'h0000_0001
`define SCS_RST_ZERO       32'h0000_0000
`define SCS_MASK_RO        32'h0000_0000
`define SCS_MASK_PM_CSR    32'h0000_0103
`define SCS_MASK_PB_SEL    32'h0000_00FF
`define SCS_MASK_ALL       32'hFFFF_FFFF

`endif

// >>> hw/scs_pkg.sv
package scs_pkg;

  // completion status returned for every request
  typedef enum logic [1:0] {
    SCS_CPL_SC,
    SCS_CPL_UR,
    SCS_CPL_CA
  } scs_cpl_t;

  // kind of storage an offset lands on
  typedef enum logic [2:0] {
    SCS_KIND_NONE,
    SCS_KIND_CONST,
    SCS_KIND_SHARED,
    SCS_KIND_LOCAL,
    SCS_KIND_UPREG
  } scs_kind_t;

endpackage : scs_pkg

// >>> hw/scs_word_reg.sv
`timescale 1ns/10ps
`include "scs_params.svh"
module scs_word_reg #(
  parameter logic [31:0] RST     = 32'h0000_0000,
  parameter logic [31:0] RW_MASK = 32'h0000_0000
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // write ports
  input  wire logic        i_cfg_we,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  input  wire logic        i_sb_we,
  input  wire logic [3:0]  i_sb_be,
  input  wire logic [31:0] i_sb_wdata,
  // stored value
  output logic      [31:0] o_q
);
  logic [31:0] q_d;

  always_comb begin
    q_d = o_q;
    for (int b = 0; b < 4; b++) begin
      if (i_sb_we && i_sb_be[b]) begin
        q_d[b*8 +: 8] = i_sb_wdata[b*8 +: 8];
      end else if (i_cfg_we && i_cfg_be[b]) begin
        q_d[b*8 +: 8] = (o_q[b*8 +: 8] & ~RW_MASK[b*8 +: 8])
                      | (i_cfg_wdata[b*8 +: 8] & RW_MASK[b*8 +: 8]);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_q <= RST;
    end else begin
      o_q <= q_d;
    end
  end
endmodule : scs_word_reg

// >>> verif/scs_host.sv
`timescale 1ns/10ps
module scs_host (
  // clock
  input  wire logic              i_clk,
  // request
  output logic                   o_valid,
  output logic                   o_mem,
  output logic                   o_wr,
  output logic                   o_ds,
  output logic [1:0]             o_port,
  output logic [13:0]            o_addr,
  output logic [9:0]             o_len,
  output logic [3:0]             o_be,
  output logic [31:0]            o_wdata,
  // completion
  input  wire logic              i_cpl_valid,
  input  wire scs_pkg::scs_cpl_t i_cpl_st,
  input  wire logic [31:0]       i_cpl_data
);
  import scs_pkg::*;
  scs_cpl_t    st;
  logic [31:0] rd;
  logic        seen;
  initial begin
    {o_valid, o_mem, o_wr, o_ds, o_port, o_addr, o_len, o_be, o_wdata} = '0;
  end
  // one request, answer sampled in the following cycle
  task go(input logic m, input logic w, input logic ds, input logic [1:0] p,
          input logic [13:0] a, input logic [9:0] l, input logic [31:0] d);
    @(negedge i_clk);
    {o_valid, o_mem, o_wr, o_ds, o_port, o_addr, o_len, o_be, o_wdata} =
      {1'b1, m, w, ds, p, a, l, 4'hF, d};
    @(negedge i_clk);
    seen = i_cpl_valid;
    st = i_cpl_st;
    rd = i_cpl_data;
    o_valid = 1'b0;
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
  endtask : go
endmodule : scs_host

// >>> verif/test_switch_port_config_space.sv
`timescale 1ns/10ps
module test_switch_port_config_space;
  import scs_pkg::*;
  typedef struct {logic m; logic [1:0] p; logic [13:0] a; logic [31:0] e;} scs_row_t;
  logic        clk = 1'b0;
  logic        nrst, sbv, valid, mem, wr, ds, cval;
  logic [1:0]  sbp, port;
  logic [11:0] sbo;
  logic [13:0] addr;
  logic [9:0]  len;
  logic [3:0]  sbb, be;
  logic [31:0] sbd, wdata, cdata;
  scs_cpl_t    cst;
  int          fail_count = 0;
  int          total_checks = 0;
  scs_row_t    rows[16];
  always #2 clk = ~clk;
  scs_cfg_space dut (.I_CLK_SYS(clk), .I_NRST(nrst), .I_REQ_VALID(valid), .I_REQ_IS_MEM(mem),
    .I_REQ_WRITE(wr), .I_REQ_FROM_DS(ds), .I_REQ_PORT(port), .I_REQ_ADDR(addr), .I_REQ_LEN(len),
    .I_REQ_BE(be), .I_REQ_WDATA(wdata), .I_SB_VALID(sbv), .I_SB_PORT(sbp), .I_SB_OFF(sbo),
    .I_SB_BE(sbb), .I_SB_WDATA(sbd), .O_CPL_VALID(cval), .O_CPL_STATUS(cst), .O_CPL_DATA(cdata));
  scs_host host (.i_clk(clk), .o_valid(valid), .o_mem(mem), .o_wr(wr), .o_ds(ds), .o_port(port),
    .o_addr(addr), .o_len(len), .o_be(be), .o_wdata(wdata), .i_cpl_valid(cval),
    .i_cpl_st(cst), .i_cpl_data(cdata));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // one-word request with success expected
  task rq(input logic m, input logic w, input logic [1:0] p, input logic [13:0] a,
          input logic [31:0] d, input logic [31:0] e);
    host.go(m, w, 1'b0, p, a, 10'h001, d);
    chk("cpl_valid", {31'h0, host.seen}, 32'h1);
    chk("cpl_status", {30'h0, host.st}, {30'h0, SCS_CPL_SC});
    chk($sformatf("data %h", a), host.rd, e);
  endtask : rq
  initial begin
    #40000;
    fail_count++;
    close_out();
  end
  initial begin
    {nrst, sbv, sbp, sbo, sbb, sbd} = '0;
    rows = '{'{0, 0, 14'h034, 32'h40}, '{0, 1, 14'h040, 32'h4801}, '{0, 2, 14'h048, 32'h6805},
      '{0, 3, 14'h068, 32'hA410}, '{0, 0, 14'h0A4, 32'h0D}, '{1, 0, 14'h1100, 32'hFB410003},
      '{0, 0, 14'hFB4, 32'h13810001}, '{0, 1, 14'hFB4, 32'h14810001},
      '{0, 0, 14'h138, 32'h14810004}, '{0, 1, 14'h138, 32'h0}, '{0, 0, 14'h148, 32'h95010002},
      '{0, 2, 14'h148, 32'h52010002}, '{0, 0, 14'h520, 32'h0}, '{0, 3, 14'h520, 32'h9501000D},
      '{1, 0, 14'h3950, 32'h0001000B}, '{0, 3, 14'h000, 32'h00010001}};
    repeat (2) @(negedge clk);
    chk("cpl_valid in reset", {31'h0, cval}, 32'h0);
    nrst = 1'b1;
    foreach (rows[i]) rq(rows[i].m, 0, rows[i].p, rows[i].a, 0, rows[i].e);
    $display("table done");
    rq(0, 1, 1, 14'h044, 32'h103, 32'h0);
    rq(0, 0, 1, 14'h044, 0, 32'h103);
    rq(0, 0, 2, 14'h044, 0, 32'h0);
    rq(0, 1, 0, 14'h200, 32'hFFFFFFFF, 32'h0);
    rq(1, 0, 0, 14'h0200, 0, 32'hFFFFFFFF);
    rq(0, 1, 1, 14'h200, 32'hFFFFFFFF, 32'h0);
    rq(0, 0, 1, 14'h200, 0, 32'h0);
    rq(1, 1, 0, 14'h2000, 32'h0, 32'h0);
    rq(0, 0, 1, 14'h000, 0, 32'h00010001);
    $display("port regions done");
    @(negedge clk);
    {sbv, sbp, sbo, sbb, sbd} = {1'b1, 2'h1, 12'h104, 4'hF, 32'hA5A50F0F};
    fork
      rq(0, 0, 3, 14'h104, 0, 32'hA5A50F0F);
      begin
        @(negedge clk);
        {sbv, sbd} = {1'b0, 32'h5A5AF0F0};
      end
    join
    rq(1, 0, 0, 14'h2104, 0, 32'hA5A50F0F);
    $display("sideband done");
    host.go(1, 0, 0, 0, 14'h0034, 10'h002, 0);
    chk("abort status", {30'h0, host.st}, {30'h0, SCS_CPL_CA});
    chk("abort data", host.rd, 32'h0);
    host.go(1, 1, 0, 0, 14'h0200, 10'h000, 32'h0);
    host.go(1, 0, 1, 0, 14'h0034, 10'h001, 0);
    chk("refused status", {30'h0, host.st}, {30'h0, SCS_CPL_UR});
    chk("refused data", host.rd, 32'h0);
    host.go(1, 1, 1, 0, 14'h0200, 10'h001, 32'h0);
    rq(0, 0, 0, 14'h200, 0, 32'hFFFFFFFF);
    $display("length errors done");
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    rq(0, 0, 1, 14'h044, 0, 32'h0);
    $display("second reset done");
    close_out();
  end
endmodule : test_switch_port_config_space
